/* verilog/cft_pkg.sv */
// Constants and carrier types for the cascadable transversal filter
package cft_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_BANK0 = 12'h000;
   localparam logic [11:0] ADDR_BANK1 = 12'h080;
   localparam logic [11:0] ADDR_SCR = 12'h100;
   localparam logic [11:0] ADDR_ACR = 12'h104;
   localparam logic [11:0] ADDR_TCR = 12'h108;
   localparam logic [11:0] ADDR_DIR = 12'h10c;
   localparam logic [11:0] ADDR_DOL = 12'h110;
   localparam logic [11:0] ADDR_DOH = 12'h114;
   localparam logic [11:0] ADDR_STAT = 12'h118;
   // Reset values
   localparam logic [15:0] SCR_RST = 16'h0000;
   localparam logic [15:0] ACR_RST = 16'h0000;
   localparam logic [15:0] TCR_RST = 16'h0000;
   localparam logic [15:0] DIR_RST = 16'h0000;
   // Datapath layout
   localparam int ACC_W = 40;
   localparam logic [2:0] PROD_SHIFT = 3'h7;
   localparam logic [1:0] ARM_ALL = 2'h3;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Coefficient word lengths
   localparam logic [1:0] CWL_4 = 2'h0;
   localparam logic [1:0] CWL_8 = 2'h1;
   localparam logic [1:0] CWL_12 = 2'h2;
   // Stage configuration register fields
   typedef struct packed {
      logic [4:0] rsv_hi;
      logic omode;
      logic [1:0] cwl;
      logic [1:0] rsv_m;
      logic [1:0] fsel;
      logic [1:0] rsv_l;
      logic src;
      logic master;
   } cft_scr_t;
   // Auxiliary control register fields
   typedef struct packed {
      logic [12:0] rsv;
      logic [1:0] arm;
      logic bank;
   } cft_acr_t;
endpackage : cft_pkg

/* verilog/cft_fir_top.sv */
// Cascadable 32-stage transversal filter with an AXI4-Lite register port
//
// Function
// - Coefficient banks are not cleared by reset; read and write in any config.
// - Two coefficient banks, every location writable and readable.
// - Reset returns config, test and aux registers to slave defaults.
// - Default slave pulses result strobe while cycle start is high.
// - Master emits cycle-start pulse when direct input is written.
// - With zero coefficients partial-sum input appears 32 cycles later.
// - Field select zero presents accumulation bits 7 to 30.
// - Result split into a low 16-bit and a high 8-bit readable word.
// - Constant input grows result per cycle, stable once filled.
// - Config 000 takes samples from the parallel sample port.
// - Aux bits 1-2 written zero then one clear the error output.
// - Config holds master, source, field, word length, output mode.
// - Config, aux and test registers written only out of reset.
// - Short coefficients sit in low bits of 16-bit registers.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module cft_fir_top #(
   parameter int NTAP = 32,
   parameter int SAMP_W = 16,
   parameter int RES_W = 24
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Cascade link to neighbouring devices
   input wire logic cycle_start_in,
   output logic cycle_start_out,
   output logic cycle_start_oe_n,
   input wire logic [SAMP_W-1:0] sample_in_port,
   input wire logic [RES_W-1:0] partial_sum_in,
   output logic [RES_W-1:0] partial_sum_out,
   output logic result_valid_strobe,
   // Open-drain error pin
   output logic error_out,
   output logic error_oe_n
);
   import cft_pkg::*;

   localparam int CA_W = $clog2(NTAP);

   cft_scr_t stage_config_reg;
   cft_acr_t aux_control_reg;
   logic [15:0] test_control_reg;
   logic [15:0] dir_r;
   logic [15:0] coef_r [2][NTAP];
   logic signed [ACC_W-1:0] acc_r [NTAP];
   logic signed [ACC_W-1:0] prod [NTAP];
   logic signed [ACC_W-1:0] casc;
   logic signed [ACC_W-1:0] shifted;
   logic [RES_W-1:0] res_r;
   logic [2:0] lsb;
   logic ovf;
   logic step;
   logic step_d1_r;
   logic step_d2_r;
   logic strobe_r;
   logic go_r;
   logic error_r;
   logic [SAMP_W-1:0] sample;
   // Write path state
   logic aw_have_r;
   logic w_have_r;
   logic [11:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic wr_go;
   logic [11:0] wa;
   logic wr_coef;
   logic wr_hit;
   // Read path state
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [31:0] rd_mux;
   logic rd_hit;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // Sign-extend a short coefficient held in the low bits
   function automatic logic signed [15:0] coef_ext(input logic [15:0] c,
      input logic [1:0] w);
      unique case (w)
         CWL_4: coef_ext = {{12{c[3]}}, c[3:0]};
         CWL_8: coef_ext = {{8{c[7]}}, c[7:0]};
         CWL_12: coef_ext = {{4{c[11]}}, c[11:0]};
         default: coef_ext = c;
      endcase
   endfunction : coef_ext

   // Write channels, taken in either order
   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready = !w_have_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_go = aw_have_r && w_have_r && !bvalid_r;
   assign wa = {aw_addr_r[11:2], 2'b00};
   assign wr_coef = wa < ADDR_SCR;
   assign wr_hit = wr_coef || (wa <= ADDR_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && !aw_have_r) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_have_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && !w_have_r) begin
         w_have_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_have_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // No reset and no gating by configuration, so banks stay reachable
   always_ff @(posedge aclk) begin
      if (wr_go && wr_coef) begin
         coef_r[wa[7]][wa[CA_W+1:2]] <= merge16(coef_r[wa[7]][wa[CA_W+1:2]],
            w_data_r, w_strb_r);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_config_reg <= SCR_RST;
      end else if (wr_go && wa == ADDR_SCR) begin
         stage_config_reg <= merge16(stage_config_reg, w_data_r,
            w_strb_r);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_control_reg <= ACR_RST;
      end else if (wr_go && wa == ADDR_ACR) begin
         aux_control_reg <= merge16(aux_control_reg, w_data_r,
            w_strb_r);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_control_reg <= TCR_RST;
      end else if (wr_go && wa == ADDR_TCR) begin
         test_control_reg <= merge16(test_control_reg, w_data_r,
            w_strb_r);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_r <= DIR_RST;
      end else if (wr_go && wa == ADDR_DIR) begin
         dir_r <= merge16(dir_r, w_data_r, w_strb_r);
      end
   end

   // Master drives the shared start line for one cycle per input write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         go_r <= 1'b0;
      end else begin
         go_r <= wr_go && wa == ADDR_DIR && stage_config_reg.master;
      end
   end
   assign cycle_start_out = go_r;
   assign cycle_start_oe_n = !stage_config_reg.master;

   // Read channel, one word answered the cycle after it is taken
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      if ({s_axi_araddr[11:2], 2'b00} < ADDR_SCR) begin
         rd_mux[15:0] = coef_r[s_axi_araddr[7]][s_axi_araddr[CA_W+1:2]];
      end else begin
         unique case ({s_axi_araddr[11:2], 2'b00})
            ADDR_SCR: rd_mux[15:0] = stage_config_reg;
            ADDR_ACR: rd_mux[15:0] = aux_control_reg;
            ADDR_TCR: rd_mux[15:0] = test_control_reg;
            ADDR_DIR: rd_mux[15:0] = dir_r;
            ADDR_DOL: rd_mux[15:0] = res_r[15:0];
            ADDR_DOH: rd_mux[RES_W-17:0] = res_r[RES_W-1:16];
            ADDR_STAT: rd_mux[0] = error_r;
            default: rd_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Any test bit set halts the filter
   assign step = cycle_start_in && ~|test_control_reg;
   assign sample = stage_config_reg.src ? dir_r : sample_in_port;
   assign casc = {{(ACC_W - RES_W - 7){partial_sum_in[RES_W-1]}},
      partial_sum_in, 7'h00};

   // Transposed form: every tap sees the sample, partial sums ripple on
   for (genvar k = 0; k < NTAP; k++) begin : g_tap
      logic signed [31:0] p;
      assign p = coef_ext(coef_r[aux_control_reg.bank][k],
         stage_config_reg.cwl) * $signed(sample);
      assign prod[k] = {{(ACC_W - 32){p[31]}}, p} <<< PROD_SHIFT;
      if (k == 0) begin : g_first
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               acc_r[k] <= '0;
            end else if (step) begin
               acc_r[k] <= casc + prod[k];
            end
         end
      end else begin : g_next
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               acc_r[k] <= '0;
            end else if (step) begin
               acc_r[k] <= acc_r[k-1] + prod[k];
            end
         end
      end
   end

   // Field window: select 0 takes bits 7 to 30
   assign lsb = PROD_SHIFT - {stage_config_reg.fsel, 1'b0};
   assign shifted = acc_r[NTAP-1] >>> lsb;
   assign ovf = !(&shifted[ACC_W-1:RES_W-1] || ~|shifted[ACC_W-1:RES_W-1]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_d1_r <= 1'b0;
         step_d2_r <= 1'b0;
         res_r <= '0;
      end else begin
         step_d1_r <= step;
         step_d2_r <= step_d1_r;
         if (step_d1_r) begin
            res_r <= shifted[RES_W-1:0];
         end
      end
   end
   assign partial_sum_out = res_r;

   // Normal output mode delays the strobe one cycle past the result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_r <= 1'b0;
      end else begin
         strobe_r <= stage_config_reg.omode ? step_d1_r : step_d2_r;
      end
   end
   assign result_valid_strobe = strobe_r;

   // Error latches only while both arm bits are set; disarming clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         error_r <= 1'b0;
      end else if (step_d1_r && ovf && aux_control_reg.arm == ARM_ALL) begin
         error_r <= 1'b1;
      end else if (aux_control_reg.arm != ARM_ALL) begin
         error_r <= 1'b0;
      end
   end
   assign error_out = 1'b0;
   assign error_oe_n = !error_r;
endmodule : cft_fir_top

/* testbench/cft_fir_checker.sv */
// Port assertions for the transversal filter
`timescale 1ns/1ps
module cft_fir_checker #(
   parameter int RES_W = 24
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Filter link
   input wire logic cycle_start_in,
   input wire logic cycle_start_out,
   input wire logic cycle_start_oe_n,
   input wire logic [RES_W-1:0] partial_sum_out,
   input wire logic result_valid_strobe,
   input wire logic error_oe_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   // Normal mode only: fast mode would strobe one cycle sooner
   strobe_cause_a: assert property (result_valid_strobe |->
      $past(cycle_start_in, 3) || $past(cycle_start_in, 4))
      else $error("strobe without step");
   result_cause_a: assert property (!$stable(partial_sum_out) |->
      $past(cycle_start_in, 2)) else $error("result moved without step");
   master_pulse_a: assert property (cycle_start_out |->
      !cycle_start_oe_n ##1 !cycle_start_out) else $error("bad start pulse");
   reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && cycle_start_oe_n && error_oe_n)
      else $error("not idle in reset");
   strobe_c: cover property (result_valid_strobe);
   pulse_c: cover property (cycle_start_out);
   error_c: cover property (!error_oe_n);
endmodule : cft_fir_checker

bind cft_fir_top cft_fir_checker #(.RES_W(RES_W)) u_chk (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .cycle_start_in, .cycle_start_out, .cycle_start_oe_n,
   .partial_sum_out, .result_valid_strobe, .error_oe_n);

/* testbench/cft_nbr.sv */
// Neighbouring devices and support logic on the cascade link
`timescale 1ns/1ps
module cft_nbr #(
   parameter int SAMP_W = 16,
   parameter int RES_W = 24
) (
   // Shared system clock
   input wire logic aclk,
   // Support logic side
   input wire logic go_ext,
   input wire logic [RES_W-1:0] up_result,
   input wire logic [SAMP_W-1:0] demux_sample,
   // Device side
   input wire logic cycle_start_out,
   input wire logic cycle_start_oe_n,
   output logic cycle_start_in,
   output logic [RES_W-1:0] partial_sum_in,
   output logic [SAMP_W-1:0] sample_in_port
);
   // Two chained devices per position would need 64 here
   // Zeroing the leading 32 coefficients lets it go
   // The lower first-column device needs only one sample
   // Wider arrays scale rate and minimum stage count
   localparam int SAMP_DLY = 32;
   logic [SAMP_W-1:0] dly_r [SAMP_DLY] = '{default: '0};
   // Shared wired-OR line, so all devices step on the same edge
   assign cycle_start_in = go_ext |
      (!cycle_start_oe_n & cycle_start_out);
   // Upstream result drives the cascade input
   assign partial_sum_in = up_result;
   // Delay advances once per step, so it counts samples, not clocks
   always @(posedge aclk) begin
      if (cycle_start_in) begin
         dly_r[0] <= demux_sample;
         for (int k = 1; k < SAMP_DLY; k++) begin
            dly_r[k] <= dly_r[k-1];
         end
      end
   end
   assign sample_in_port = dly_r[SAMP_DLY-1];
endmodule : cft_nbr

/* testbench/cft_fir_top_test.sv */
// Self-checking bench for the transversal filter
`timescale 1ns/1ps
module cft_fir_top_test;
   import cft_pkg::*;
   logic aclk, aresetn, go, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, cycle_start_in;
   logic cycle_start_out, cycle_start_oe_n, result_valid_strobe;
   logic error_out, error_oe_n;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, lf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] samp, sample_in_port;
   logic [23:0] psum, partial_sum_in, partial_sum_out, v;
   logic [15:0] mem [64];
   int err_count, total_checks, n_strb, n_go, i;
   cft_fir_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cycle_start_in, .cycle_start_out, .cycle_start_oe_n,
      .sample_in_port, .partial_sum_in, .partial_sum_out,
      .result_valid_strobe, .error_out, .error_oe_n);
   cft_nbr u_nbr (.aclk, .go_ext(go), .up_result(psum), .demux_sample(samp),
      .cycle_start_out, .cycle_start_oe_n, .cycle_start_in, .partial_sum_in,
      .sample_in_port);
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   // Settled result once n steps of one product have filled the chain
   function automatic logic [31:0] fir_out(input logic signed [15:0] c,
      input logic signed [15:0] x, input int n);
      return {8'h00, 24'(n * c * x)};
   endfunction : fir_out
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // Ready is raised only once the answer shows, so holding is exercised
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      rsp = 2'h3;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (rsp === 2'h3 && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) rsp = s_axi_bresp;
         else if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      if (n >= 50) chk("bus", 0, 1);
      @(posedge aclk);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      int n;
      n = 0;
      rsp = 2'h3;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (rsp === 2'h3 && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            rsp = s_axi_rresp;
            rd = s_axi_rdata;
         end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      if (n >= 50) chk("bus", 0, 1);
      @(posedge aclk);
   endtask : rdr
   task automatic reset_dut;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : reset_dut
   task automatic step(input int n);
      go <= 1'b1;
      repeat (n) @(posedge aclk);
      go <= 1'b0;
      repeat (5) @(posedge aclk);
   endtask : step
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (result_valid_strobe === 1'b1) n_strb++;
      if (cycle_start_out === 1'b1) n_go++;
   end
   // Whole run needs under two thousand cycles; fifteen times that is a hang
   initial begin
      repeat (30000) @(posedge aclk);
      err_count++;
      summarize;
   end
   initial begin
      {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, psum, samp} = '0;
      lf = 32'ha408202f;
      reset_dut;
      wr(ADDR_SCR, 32'h733); // Busy config must not disturb banks
      for (i = 0; i < 64; i++) begin
         lf = lfsr_next(lf);
         mem[i] = lf[15:0];
         wr(12'(4 * i), {16'h0, mem[i]});
      end
      for (i = 0; i < 64; i++) begin
         rdr(12'(4 * i));
         chk("coef", {16'h0, mem[i]}, rd);
      end
      $display("banks done");
      wr(ADDR_ACR, 32'h7);
      rdr(ADDR_SCR);
      chk("config", 32'h733, rd);
      rdr(ADDR_ACR);
      chk("aux", 32'h7, rd);
      wr(12'h200, 32'h1);
      chk("wr resp", RESP_SLVERR, rsp);
      rdr(12'h200);
      chk("rd resp", RESP_SLVERR, rsp);
      reset_dut;
      for (i = 0; i < 3; i++) begin
         rdr(ADDR_SCR + 12'(4 * i));
         chk("ctl reset", 32'h0, rd);
      end
      $display("registers done");
      n_strb = 0;
      step(8);
      chk("strobes", 8, n_strb);
      wr(ADDR_TCR, 32'h1);
      step(8);
      chk("halted", 8, n_strb);
      wr(ADDR_TCR, 32'h0);
      $display("strobe done");
      for (i = 0; i < 32; i++) wr(12'(4 * i), 32'h0);
      lf = lfsr_next(lf);
      v = lf[23:0];
      psum <= v;
      reset_dut;
      step(31);
      chk("fill 31", 32'h0, partial_sum_out);
      step(1);
      chk("fill 32", v, partial_sum_out);
      rdr(ADDR_DOL);
      chk("low word", v[15:0], rd);
      rdr(ADDR_DOH);
      chk("high word", v[23:16], rd);
      $display("cascade done");
      for (i = 0; i < 32; i++) wr(12'(4 * i), 32'h4);
      psum <= '0;
      reset_dut;
      wr(ADDR_SCR, 32'h2); // Slave on direct input
      wr(ADDR_DIR, 32'h1002);
      for (i = 1; i <= 32; i++) begin
         step(1);
         chk("ramp", 32'h4008 * i, partial_sum_out);
      end
      step(4);
      chk("stable", 32'h80100, partial_sum_out);
      wr(ADDR_SCR, 32'h0);
      lf = lfsr_next(lf);
      samp <= lf[15:0];
      // Half the steps only push the sample through the column delay
      step(64);
      chk("port", fir_out(16'h4, samp, 32), partial_sum_out);
      // 0xf4 as an 8-bit coefficient is minus twelve
      for (i = 32; i < 64; i++) wr(12'(4 * i), 32'hf4);
      wr(ADDR_ACR, 32'h1);
      wr(ADDR_SCR, 32'h102); // Direct input, 8-bit coefficients
      wr(ADDR_DIR, {16'h0, samp});
      step(32);
      chk("cwl8", fir_out(16'hfff4, samp, 32), partial_sum_out);
      $display("datapath done");
      wr(ADDR_SCR, 32'h3); // Master
      n_go = 0;
      wr(ADDR_DIR, 32'h1002);
      repeat (3) @(posedge aclk);
      chk("start pulse", 1, n_go);
      wr(ADDR_SCR, 32'h332);
      wr(ADDR_DIR, 32'h7fff);
      wr(ADDR_ACR, 32'h6);
      step(32);
      chk("error set", 0, error_oe_n);
      chk("error pin", 0, error_out);
      rdr(ADDR_STAT);
      chk("status", 32'h1, rd);
      wr(ADDR_DIR, 32'h0);
      step(33);
      chk("error held", 0, error_oe_n);
      wr(ADDR_ACR, 32'h0);
      wr(ADDR_ACR, 32'h6);
      chk("error clear", 1, error_oe_n);
      $display("master and error done");
      summarize;
   end
endmodule : cft_fir_top_test
